/* File: rtl/elastic_align_rx_monitor_ctrl.sv */
// Purpose: Control register holding store align requests and monitor select
// Assumes: Store pointers and slot stream are synchronous to clk
// Notes: Pointers are 5-bit byte indices into a one-frame window
`default_nettype none
// Notes on behaviour
// - A rising rx align bit sets the rx pointers half a frame apart.
// - If separation is already half a frame or more nothing is changed.
// - Below half a frame the store is realigned and data is disturbed.
// - Only a zero to one change of an align bit triggers an alignment.
// - A rising transmit align bit does the same for the transmit store.
// - Bits four to zero select which receive channel is monitored.
module elastic_align_rx_monitor_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic [4:0] rxWrPtr,
  input wire logic [4:0] rxRdPtr,
  output logic rxAlignLoad,
  output logic [4:0] rxAlignRdPtr,
  output logic rxAlignCorrupt,
  input wire logic [4:0] txWrPtr,
  input wire logic [4:0] txRdPtr,
  output logic txAlignLoad,
  output logic [4:0] txAlignRdPtr,
  output logic txAlignCorrupt,
  input wire logic slotValid,
  input wire logic [4:0] slotNum,
  input wire logic [7:0] slotData,
  output logic [7:0] rxChannelMonitorValue
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdData_q;
  logic rxReqPrev_q, txReqPrev_q;
  logic rxLoad_q, txLoad_q;
  logic [4:0] rxPtr_q, txPtr_q;
  logic [4:0] selLatched_q;
  logic [7:0] monitor_q;

  // Modulo-32 distance from read to write pointer
  function automatic logic [4:0] sep(input logic [4:0] w, input logic [4:0] r);
    sep = w - r;
  endfunction : sep

  // Read pointer half a frame behind a write pointer, modulo one frame
  function automatic logic [4:0] halfBehind(input logic [4:0] w);
    halfBehind = w - elastic_align_pkg::HALF_FRAME;
  endfunction : halfBehind

  wire hit = addr == elastic_align_pkg::ALIGN_SEL_ADDR;
  wire regWrite = wrEn && hit;
  wire rxRequest = ctrl_q[elastic_align_pkg::RX_ALIGN_BIT];
  wire txRequest = ctrl_q[elastic_align_pkg::TX_ALIGN_BIT];
  wire rxRise = rxRequest && !rxReqPrev_q;
  wire txRise = txRequest && !txReqPrev_q;
  wire rxClose = sep(rxWrPtr, rxRdPtr) < elastic_align_pkg::HALF_FRAME;
  wire txClose = sep(txWrPtr, txRdPtr) < elastic_align_pkg::HALF_FRAME;
  wire rxDoAlign = rxRise && rxClose;
  wire txDoAlign = txRise && txClose;
  wire [4:0] selNow = ctrl_q[elastic_align_pkg::SEL_MSB:
                             elastic_align_pkg::SEL_LSB];
  wire frameEnd = slotValid && slotNum == elastic_align_pkg::LAST_SLOT;
  // Slot of the monitored channel in the current frame
  wire selSlot = slotValid && slotNum == selLatched_q;

  // Bit seven is forced low so a careless write cannot leave it set
  assign ctrl_d = regWrite ? (wrData & elastic_align_pkg::WRITE_MASK)
                           : ctrl_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= elastic_align_pkg::ALIGN_SEL_RESET;
      rxReqPrev_q <= 1'b0;
      txReqPrev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rxReqPrev_q <= rxRequest;
      txReqPrev_q <= txRequest;
    end
  end

  // Read pointer is moved half a frame behind the write pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      rxLoad_q <= 1'b0;
      txLoad_q <= 1'b0;
      rxPtr_q <= 5'h00;
      txPtr_q <= 5'h00;
    end else begin
      rxLoad_q <= rxDoAlign;
      txLoad_q <= txDoAlign;
      if (rxDoAlign) begin
        rxPtr_q <= halfBehind(rxWrPtr);
      end
      if (txDoAlign) begin
        txPtr_q <= halfBehind(txWrPtr);
      end
    end
  end

  // Load and corrupt share one pulse: the store drops its data while moving
  assign rxAlignLoad = rxLoad_q;
  assign txAlignLoad = txLoad_q;
  assign rxAlignCorrupt = rxLoad_q;
  assign txAlignCorrupt = txLoad_q;
  assign rxAlignRdPtr = rxPtr_q;
  assign txAlignRdPtr = txPtr_q;

  // Selection is sampled at frame end so a frame never mixes two channels
  always_ff @(posedge clk) begin
    if (rst) begin
      selLatched_q <= 5'h00;
      monitor_q <= 8'h00;
    end else begin
      if (frameEnd) begin
        selLatched_q <= selNow;
      end
      if (selSlot) begin
        monitor_q <= slotData;
      end
    end
  end
  assign rxChannelMonitorValue = monitor_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (rdEn) begin
      rdData_q <= hit ? ctrl_q : 8'h00;
    end
  end
  assign rdData = rdData_q;

  // Checks written with |=> look one edge past the edge that decides them; the others check that same edge
  a_top_bit_zero: assert property (
    @(posedge clk) disable iff (rst) !ctrl_q[7])
    else $error("bit seven set");
  a_readback_top: assert property (
    @(posedge clk) disable iff (rst) rdEn |=> !rdData[7])
    else $error("bit seven read back set");
  a_rx_align_close: assert property (
    @(posedge clk) disable iff (rst)
    rxRise && rxClose |=> rxAlignLoad &&
      rxAlignRdPtr == $past(rxWrPtr) - 5'h10)
    else $error("rx align missed");
  a_rx_align_far: assert property (
    @(posedge clk) disable iff (rst)
    rxRise && !rxClose |=> !rxAlignLoad && $stable(rxAlignRdPtr))
    else $error("rx align acted far");
  a_tx_align_far: assert property (
    @(posedge clk) disable iff (rst)
    txRise && !txClose |=> !txAlignLoad && $stable(txAlignRdPtr))
    else $error("tx align acted far");
  a_corrupt_flag: assert property (
    @(posedge clk) disable iff (rst) rxAlignLoad |-> rxAlignCorrupt)
    else $error("no rx corrupt");
  a_tx_corrupt_flag: assert property (
    @(posedge clk) disable iff (rst) txAlignLoad |-> txAlignCorrupt)
    else $error("no tx corrupt");
  a_level_no_retrig: assert property (
    @(posedge clk) disable iff (rst) rxAlignLoad |=> !rxAlignLoad)
    else $error("rx retriggered");
  a_tx_no_retrig: assert property (
    @(posedge clk) disable iff (rst) txAlignLoad |=> !txAlignLoad)
    else $error("tx retriggered");
  a_rx_held_quiet: assert property (
    @(posedge clk) disable iff (rst)
    rxRequest && rxReqPrev_q |=> !rxAlignLoad)
    else $error("rx held bit realigned");
  a_tx_held_quiet: assert property (
    @(posedge clk) disable iff (rst)
    txRequest && txReqPrev_q |=> !txAlignLoad)
    else $error("tx held bit realigned");
  a_tx_align_close: assert property (
    @(posedge clk) disable iff (rst)
    txRise && txClose |=> txAlignLoad &&
      txAlignRdPtr == $past(txWrPtr) - 5'h10)
    else $error("tx align missed");
  a_monitor_capture: assert property (
    @(posedge clk) disable iff (rst)
    slotValid && slotNum == selLatched_q |=> monitor_q == $past(slotData))
    else $error("monitor miss");
  a_monitor_hold: assert property (
    @(posedge clk) disable iff (rst)
    !(slotValid && slotNum == selLatched_q) |=> $stable(monitor_q))
    else $error("monitor changed off its slot");
  a_sel_frame: assert property (
    @(posedge clk) disable iff (rst)
    !$past(frameEnd) |-> $stable(selLatched_q))
    else $error("select moved mid frame");
  a_sel_follow: assert property (
    @(posedge clk) disable iff (rst)
    frameEnd |=> selLatched_q == $past(selNow))
    else $error("select not taken at frame end");
  a_reset_quiet: assert property (@(posedge clk)
    rst |=> !rxAlignLoad && !txAlignLoad && rdData == 8'h00 &&
      rxChannelMonitorValue == 8'h00)
    else $error("outputs not cleared by reset");
  a_rd_value: assert property (
    @(posedge clk) disable iff (rst) rdEn && hit |=> rdData == $past(ctrl_q))
    else $error("read data differs from register");
  a_rd_unmapped: assert property (
    @(posedge clk) disable iff (rst)
    rdEn && !hit |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (
    @(posedge clk) disable iff (rst) !rdEn |=> $stable(rdData))
    else $error("read data moved");

  c_rx_align: cover property (@(posedge clk) rxAlignLoad);
  c_tx_align: cover property (@(posedge clk) txAlignLoad);
  c_rx_noop: cover property (@(posedge clk) rxRise && !rxClose);
  c_tx_noop: cover property (@(posedge clk) txRise && !txClose);
  c_sel_change: cover property (@(posedge clk)
    frameEnd && selNow != selLatched_q);
endmodule : elastic_align_rx_monitor_ctrl
`default_nettype wire

/* File: rtl/elastic_align_pkg.sv */
// Purpose: Constants for the elastic store align and receive monitor select
// Assumes: One framer, 8-bit control port, 40 MHz clock
// Notes: Frame is 32 timeslots; half a frame is 16 bytes of separation
`default_nettype none
package elastic_align_pkg;
  localparam logic [7:0] ALIGN_SEL_ADDR = 8'haa;
  localparam logic [7:0] ALIGN_SEL_RESET = 8'h00;
  localparam int RX_ALIGN_BIT = 6;
  localparam int TX_ALIGN_BIT = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;
  localparam logic [7:0] WRITE_MASK = 8'h7f;
  localparam logic [4:0] HALF_FRAME = 5'h10;
  localparam logic [4:0] LAST_SLOT = 5'h1f;
endpackage : elastic_align_pkg
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the store align and monitor select logic
// Assumes: Inputs change on the falling edge; outputs are read there as well
// Notes: Align results are read one falling edge after the write returns
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wrEn = 0, rdEn = 0, slotValid = 0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, slotData = 8'h00, rdData, mon;
  logic [4:0] rxW = 5'h00, rxR = 5'h00, txW = 5'h00, txR = 5'h00;
  logic [4:0] slotNum = 5'h00, rxP, txP;
  logic rxL, rxC, txL, txC;
  int errTotal = 0, samplesChecked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  elastic_align_rx_monitor_ctrl dut (.clk(clk), .rst(rst), .wrEn(wrEn),
    .rdEn(rdEn), .addr(addr), .wrData(wrData), .rdData(rdData),
    .rxWrPtr(rxW), .rxRdPtr(rxR), .rxAlignLoad(rxL), .rxAlignRdPtr(rxP),
    .rxAlignCorrupt(rxC), .txWrPtr(txW), .txRdPtr(txR), .txAlignLoad(txL),
    .txAlignRdPtr(txP), .txAlignCorrupt(txC), .slotValid(slotValid),
    .slotNum(slotNum), .slotData(slotData), .rxChannelMonitorValue(mon));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samplesChecked++;
    if (s !== e) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tallyAndFinish;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tallyAndFinish
  // Whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errTotal++;
      tallyAndFinish;
    end
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wrEn = 1; addr = a; wrData = d;
    @(negedge clk);
    wrEn = 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clk);
    rdEn = 1; addr = a;
    @(negedge clk);
    rdEn = 0;
    @(negedge clk);
    chk(n, rdData, e);
  endtask : rd
  task regTest;
    rd(8'haa, 8'h00, "resetValue");
    wr(8'haa, 8'hff);
    rd(8'haa, 8'h7f, "topBitMasked");
    wr(8'h55, 8'h1f);
    rd(8'h55, 8'h00, "unmapped");
    rd(8'haa, 8'h7f, "keptValue");
    $display("register test done");
  endtask : regTest
  // A held bit is tried by skipping the clearing write
  task alignTest(input int b, input logic [4:0] w, input logic [4:0] r,
                 input logic clear, input logic e);
    logic [4:0] old, seen;
    {rxW, rxR, txW, txR} = {w, r, w, r};
    old = b == 6 ? rxP : txP;
    if (clear) wr(8'haa, 8'h00);
    wr(8'haa, 8'h01 << b);
    // The load pulse stands only in the cycle after the edge that follows the write edge
    @(negedge clk);
    seen = b == 6 ? rxP : txP;
    chk("rxLoad", {6'h00, rxL, rxC}, {6'h00, {2{e && b == 6}}});
    chk("txLoad", {6'h00, txL, txC}, {6'h00, {2{e && b == 5}}});
    if (e) chk("newPtr", {3'h0, seen}, {3'h0, w - 5'h10});
    else chk("keptPtr", {3'h0, seen}, {3'h0, old});
    $display("align test done");
  endtask : alignTest
  task frame(input logic [2:0] k);
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      slotValid = 1; slotNum = i[4:0]; slotData = {k, i[4:0]};
    end
    @(negedge clk);
    slotValid = 0;
  endtask : frame
  task monTest;
    wr(8'haa, 8'h03);
    frame(3'h0);
    frame(3'h1);
    chk("monitor", mon, {3'h1, 5'h03});
    wr(8'haa, 8'h14);
    frame(3'h2);
    chk("monitorOld", mon, {3'h2, 5'h03});
    frame(3'h3);
    chk("monitorNew", mon, {3'h3, 5'h14});
    wr(8'haa, 8'h0b);
    frame(3'h4);
    frame(3'h5);
    chk("monitorBit3", mon, {3'h5, 5'h0b});
    $display("monitor test done");
  endtask : monTest
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    regTest;
    alignTest(6, 5'h05, 5'h00, 1, 1);
    alignTest(6, 5'h05, 5'h00, 0, 0);
    alignTest(6, 5'h10, 5'h00, 1, 0);
    alignTest(6, 5'h03, 5'h14, 1, 1);
    alignTest(5, 5'h0f, 5'h00, 1, 1);
    alignTest(5, 5'h1f, 5'h0f, 1, 0);
    monTest;
    tallyAndFinish;
  end
endmodule : tb_top
`default_nettype wire
